// ### wake_seq_pkg.sv
// constants, register map and state codes for the start-up and wake sequencer
// assumes a single 20 MHz reference clock shared by every user of the package
package wake_seq_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned QUAL_TIME_MS = 40;
  localparam int unsigned SLOT_TIME_US = 1280;
  localparam int unsigned SLOT_TIMEOUT_MS = 10;
  localparam int unsigned RETRY_TIME_MS = 200;
  // least times divide exactly at 20 MHz, so the qualifier holds for at least the full time
  localparam int unsigned QUAL_CYCLES = (CLK_HZ / 1000 * QUAL_TIME_MS + 0);
  localparam int unsigned SLOT_CYCLES = (CLK_HZ / 1_000_000 * SLOT_TIME_US);
  localparam int unsigned SLOT_TIMEOUT_CYCLES = (CLK_HZ / 1000 * SLOT_TIMEOUT_MS);
  localparam int unsigned RETRY_CYCLES = (CLK_HZ / 1000 * RETRY_TIME_MS);
  localparam int unsigned QUAL_CNT_W = 20;
  localparam int unsigned TIMER_W = 23;

  // ==========================================================
  // sequencer shape
  localparam int unsigned NUM_SUPPLIES = 11;
  localparam int unsigned NUM_SLOTS = 14;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned MAX_RETRIES = 8;
  localparam int unsigned TRIES_W = 4;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_WAKE_CAUSE_STATUS = 8'h1F;
  localparam logic [7:0] ADDR_WAKE_CAUSE_MASK = 8'h27;
  localparam int unsigned REG_W = 16;
  localparam int unsigned CAUSE_W = 7;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [6:0] STATUS_RESET = 7'h00;

  // wake cause bit positions
  localparam int unsigned BIT_WOKE_FROM_OFF = 6;
  localparam int unsigned BIT_WOKE_FROM_SLEEP = 5;
  localparam int unsigned BIT_WOKE_BY_CONV_FAULT = 4;
  localparam int unsigned BIT_WOKE_BY_WATCHDOG = 3;
  localparam int unsigned BIT_WOKE_BY_GPIO_POWERON = 2;
  localparam int unsigned BIT_WOKE_BY_KEY = 1;
  localparam int unsigned BIT_WOKE_BY_GPIO_WAKE = 0;

  // gpio_pin_config field positions
  localparam int unsigned GCFG_WAKE_EN = 0;
  localparam int unsigned GCFG_WAKE_POL = 1;
  localparam int unsigned GCFG_PWRON_EN = 2;
  localparam int unsigned GCFG_PWRON_POL = 3;

  // ==========================================================
  // power states
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_SLEEP = 3'h1,
    ST_SEQ = 3'h2,
    ST_ACTIVE = 3'h3,
    ST_RETRY = 3'h4
  } power_state_e;

endpackage : wake_seq_pkg

// ### sync_stage.sv
// two-flop synchroniser for a group of unrelated levels
// assumes each bit is a slow level; no multi-bit coherence is given
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  always_comb begin
    d = q;
    d.meta = async_in;
    d.stable = q.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule : sync_stage
`default_nettype wire

// ### wake_qualifier.sv
// hold-time qualifier for one wake input
// assumes the sample input is already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module wake_qualifier #(
  parameter int unsigned LIMIT = wake_seq_pkg::QUAL_CYCLES,
  parameter int unsigned CW = wake_seq_pkg::QUAL_CNT_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // input and its configuration
  input wire logic sample,
  input wire logic active_high,
  input wire logic enable,
  // result
  output logic qualified
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic qual;
  } qual_s;

  qual_s q;
  qual_s d;
  logic at_level;

  always_comb begin
    d = q;
    at_level = enable && (sample == active_high);
    if (!at_level) begin
      d.cnt = '0;
      d.qual = 1'b0;
    end else if (q.cnt != CW'(LIMIT)) begin
      d.cnt = q.cnt + CW'(1);
    end else begin
      // counter saturated: held longer than the limit
      d.qual = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign qualified = q.qual;

endmodule : wake_qualifier
`default_nettype wire

// ### startup_wake_sequencer.sv
// start-up qualification, wake-cause flags and timeslot power-up sequencer
// assumes pins and analog detectors are asynchronous; config and fault inputs
// come from logic on ref_clk; registers are reached over a simple strobe port
//
// Operation
// - off or sleep goes active on event
// - key counts after 40ms at polarity
// - gpio wake counts after 40ms held
// - gpio power-on counts after 40ms held
// - rtc alarm wakes only when enabled
// - adaptor above 4.0V is an event
// - usb above line is an event
// - events ignored below start-up threshold
// - usb start: suspend battery, else usb+trickle
// - battery attach alone never starts
// - bit 6 rises on start from off
// - bit 5 rises on start from sleep
// - bit 4 marks converter fault reset
// - bit 3 marks watchdog reset
// - bit 2 marks gpio power-on qualified
// - bit 1 marks key qualified
// - bit 0 marks gpio wake qualified
// - rising-edge set, cleared by status read
// - mask bits 6:0, one masks, reset zero
// - summary irq when any unmasked status set
// - walk fourteen slots enabling supplies
// - advance after 1.28ms and 90% reached
// - fault retries 8 times, 200ms apart
// - system-on flag set after the last slot
`timescale 1ns/1ps
`default_nettype none
module startup_wake_sequencer #(
  parameter int unsigned N = wake_seq_pkg::NUM_SUPPLIES,
  parameter int unsigned QUAL_LIMIT = wake_seq_pkg::QUAL_CYCLES,
  parameter int unsigned SLOT_LIMIT = wake_seq_pkg::SLOT_CYCLES,
  parameter int unsigned SLOT_TIMEOUT = wake_seq_pkg::SLOT_TIMEOUT_CYCLES,
  parameter int unsigned RETRY_LIMIT = wake_seq_pkg::RETRY_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // asynchronous wake pins and detectors
  input wire logic key_pin,
  input wire logic gpio_wake_pin,
  input wire logic gpio_poweron_input,
  input wire logic rtc_alarm,
  input wire logic adaptor_feedback,
  input wire logic usb_above_line,
  input wire logic line_above_startup,
  input wire logic [N-1:0] supply_good,
  // configuration from the register block
  input wire logic key_input_polarity,
  input wire logic [3:0] gpio_pin_config,
  input wire logic rtc_alarm_wake_en,
  input wire logic usb_suspend,
  input wire logic fault_restart_enable,
  input wire logic hibernate_req,
  input wire logic [N*wake_seq_pkg::SLOT_W-1:0] supply_slot,
  // reset causes from fault logic
  input wire logic conv_fault_reset,
  input wire logic wdog_reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [wake_seq_pkg::REG_W-1:0] reg_wdata,
  output logic [wake_seq_pkg::REG_W-1:0] reg_rdata,
  // power control outputs
  output logic [N-1:0] supply_en,
  output logic system_on,
  output logic run_from_usb,
  output logic trickle_100ma_en,
  output logic wake_summary_irq,
  output logic [2:0] power_state,
  output logic [wake_seq_pkg::SLOT_W-1:0] current_slot
);

  // ==========================================================
  // state record
  localparam int unsigned SYNC_W = 7 + N;
  localparam int unsigned TW = wake_seq_pkg::TIMER_W;
  localparam int unsigned SW = wake_seq_pkg::SLOT_W;
  localparam int unsigned CW = wake_seq_pkg::CAUSE_W;

  typedef struct packed {
    wake_seq_pkg::power_state_e state;
    logic [SW-1:0] slot;
    logic [TW-1:0] timer;
    logic [wake_seq_pkg::TRIES_W-1:0] tries;
    logic origin_off;
    logic chip_on;
    logic usb_start;
    logic usb_run;
    logic trickle;
    logic adp_prev;
    logic usb_prev;
    logic [CW-1:0] cause_prev;
    logic [CW-1:0] status;
    logic [CW-1:0] mask;
    logic [wake_seq_pkg::REG_W-1:0] rdata;
    logic [N-1:0] en;
    logic irq;
  } seq_s;

  seq_s q;
  seq_s d;

  // ==========================================================
  // synchronisers and qualifiers
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_lvl;
  logic key_s;
  logic gwake_s;
  logic gpwr_s;
  logic rtc_s;
  logic adp_s;
  logic usb_s;
  logic line_s;
  logic [N-1:0] good_s;
  logic key_qual;
  logic gwake_qual;
  logic gpwr_qual;

  assign sync_raw = {supply_good, line_above_startup, usb_above_line, adaptor_feedback,
                     rtc_alarm, gpio_poweron_input, gpio_wake_pin, key_pin};
  assign key_s = sync_lvl[0];
  assign gwake_s = sync_lvl[1];
  assign gpwr_s = sync_lvl[2];
  assign rtc_s = sync_lvl[3];
  assign adp_s = sync_lvl[4];
  assign usb_s = sync_lvl[5];
  assign line_s = sync_lvl[6];
  assign good_s = sync_lvl[SYNC_W-1:7];

  sync_stage #(
    .W(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(sync_raw),
    .sync_out(sync_lvl)
  );

  wake_qualifier #(
    .LIMIT(QUAL_LIMIT),
    .CW(wake_seq_pkg::QUAL_CNT_W)
  ) u_key_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample(key_s),
    .active_high(!key_input_polarity),
    .enable(1'b1),
    .qualified(key_qual)
  );

  wake_qualifier #(
    .LIMIT(QUAL_LIMIT),
    .CW(wake_seq_pkg::QUAL_CNT_W)
  ) u_gwake_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample(gwake_s),
    .active_high(gpio_pin_config[wake_seq_pkg::GCFG_WAKE_POL]),
    .enable(gpio_pin_config[wake_seq_pkg::GCFG_WAKE_EN]),
    .qualified(gwake_qual)
  );

  wake_qualifier #(
    .LIMIT(QUAL_LIMIT),
    .CW(wake_seq_pkg::QUAL_CNT_W)
  ) u_gpwr_qual (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample(gpwr_s),
    .active_high(gpio_pin_config[wake_seq_pkg::GCFG_PWRON_POL]),
    .enable(gpio_pin_config[wake_seq_pkg::GCFG_PWRON_EN]),
    .qualified(gpwr_qual)
  );

  // ==========================================================
  // next-state logic
  logic adp_event;
  logic usb_event;
  logic wake_event;
  logic slot_ok;
  logic [CW-1:0] cause;
  logic [CW-1:0] cause_set;
  logic status_rd;
  logic [SW-1:0] s_i;

  always_comb begin
    d = q;
    s_i = '0;
    adp_event = adp_s && !q.adp_prev;
    usb_event = usb_s && !q.usb_prev;
    d.adp_prev = adp_s;
    d.usb_prev = usb_s;
    // threshold gate; alarm enable; no battery term here
    wake_event = line_s && (key_qual || gwake_qual || gpwr_qual ||
                            (rtc_s && rtc_alarm_wake_en) || adp_event || usb_event);

    // every supply of this slot at 90%
    slot_ok = 1'b1;
    for (int i = 0; i < N; i++) begin
      s_i = supply_slot[i*SW +: SW];
      if (s_i == q.slot && !good_s[i]) begin
        slot_ok = 1'b0;
      end
    end

    unique case (q.state)
      wake_seq_pkg::ST_OFF: begin
        d.en = '0;
        d.chip_on = 1'b0;
        d.usb_run = 1'b0;
        d.trickle = 1'b0;
        if (wake_event) begin
          d.state = wake_seq_pkg::ST_SEQ;
          d.slot = SW'(1);
          d.timer = '0;
          d.tries = '0;
          d.origin_off = 1'b1;
          d.usb_start = usb_event;
        end
      end
      wake_seq_pkg::ST_SLEEP: begin
        if (wake_event) begin
          d.state = wake_seq_pkg::ST_SEQ;
          d.slot = SW'(1);
          d.timer = '0;
          d.tries = '0;
          d.origin_off = 1'b0;
          d.usb_start = usb_event;
        end
      end
      wake_seq_pkg::ST_SEQ: begin
        d.timer = q.timer + TW'(1);
        d.usb_run = q.usb_start && !usb_suspend;
        d.trickle = q.usb_start && !usb_suspend;
        // enable supplies up to this slot; spread is the configurer's job
        for (int i = 0; i < N; i++) begin
          s_i = supply_slot[i*SW +: SW];
          d.en[i] = (s_i != '0) && (s_i <= q.slot);
        end
        if (q.timer >= TW'(SLOT_LIMIT - 1) && slot_ok) begin
          d.timer = '0;
          // active only after the last slot
          if (q.slot == SW'(wake_seq_pkg::NUM_SLOTS)) begin
            d.state = wake_seq_pkg::ST_ACTIVE;
            d.chip_on = 1'b1;
          end else begin
            d.slot = q.slot + SW'(1);
          end
        end else if (q.timer >= TW'(SLOT_TIMEOUT - 1)) begin
          d.timer = '0;
          d.en = '0;
          d.chip_on = 1'b0;
          if (fault_restart_enable &&
              q.tries < wake_seq_pkg::TRIES_W'(wake_seq_pkg::MAX_RETRIES)) begin
            d.state = wake_seq_pkg::ST_RETRY;
            d.tries = q.tries + wake_seq_pkg::TRIES_W'(1);
          end else begin
            d.state = wake_seq_pkg::ST_OFF;
            d.tries = '0;
          end
        end
      end
      wake_seq_pkg::ST_RETRY: begin
        d.en = '0;
        d.timer = q.timer + TW'(1);
        if (q.timer >= TW'(RETRY_LIMIT - 1)) begin
          d.state = wake_seq_pkg::ST_SEQ;
          d.slot = SW'(1);
          d.timer = '0;
        end
      end
      wake_seq_pkg::ST_ACTIVE: begin
        d.tries = '0;
        if (hibernate_req) begin
          d.state = wake_seq_pkg::ST_SLEEP;
        end
      end
      default: begin
        // unused codes fall back to off
        d.state = wake_seq_pkg::ST_OFF;
      end
    endcase

    // ==========================================================
    // wake-cause flags
    cause = '0;
    cause[wake_seq_pkg::BIT_WOKE_FROM_OFF] = (q.state == wake_seq_pkg::ST_ACTIVE) && q.origin_off;
    cause[wake_seq_pkg::BIT_WOKE_FROM_SLEEP] = (q.state == wake_seq_pkg::ST_ACTIVE) && !q.origin_off;
    cause[wake_seq_pkg::BIT_WOKE_BY_CONV_FAULT] = conv_fault_reset;
    cause[wake_seq_pkg::BIT_WOKE_BY_WATCHDOG] = wdog_reset;
    cause[wake_seq_pkg::BIT_WOKE_BY_GPIO_POWERON] = gpwr_qual;
    cause[wake_seq_pkg::BIT_WOKE_BY_KEY] = key_qual;
    cause[wake_seq_pkg::BIT_WOKE_BY_GPIO_WAKE] = gwake_qual;
    d.cause_prev = cause;

    // rising edge sets, read clears, set wins
    cause_set = cause & ~q.cause_prev;
    status_rd = reg_rd && (reg_addr == wake_seq_pkg::ADDR_WAKE_CAUSE_STATUS);
    d.status = (status_rd ? '0 : q.status) | cause_set;

    // ==========================================================
    // register port
    // mask storage, upper bits read zero
    if (reg_wr && reg_addr == wake_seq_pkg::ADDR_WAKE_CAUSE_MASK) begin
      d.mask = reg_wdata[CW-1:0];
    end
    d.rdata = '0;
    if (status_rd) begin
      d.rdata = {{(wake_seq_pkg::REG_W - CW){1'b0}}, q.status};
    end else if (reg_rd && reg_addr == wake_seq_pkg::ADDR_WAKE_CAUSE_MASK) begin
      d.rdata = {{(wake_seq_pkg::REG_W - CW){1'b0}}, q.mask};
    end else if (reg_rd) begin
      d.rdata = '0;
    end else begin
      // holds the last answer between reads
      d.rdata = q.rdata;
    end

    d.irq = |(d.status & ~d.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q <= '0;
      q.state <= wake_seq_pkg::ST_OFF;
      q.mask <= wake_seq_pkg::MASK_RESET;
      q.status <= wake_seq_pkg::STATUS_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata = q.rdata;
  assign supply_en = q.en;
  assign system_on = q.chip_on;
  assign run_from_usb = q.usb_run;
  assign trickle_100ma_en = q.trickle;
  assign wake_summary_irq = q.irq;
  assign power_state = q.state;
  assign current_slot = q.slot;

endmodule : startup_wake_sequencer
`default_nettype wire

// ### wake_seq_props.sv
// concurrent checks on the start-up sequencer's ports
// assumes it is bound into startup_wake_sequencer; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module wake_seq_props #(
  parameter int unsigned N = 11,
  parameter int unsigned SLOT_LIMIT = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // watched inputs
  input wire logic conv_fault_reset,
  input wire logic [N*wake_seq_pkg::SLOT_W-1:0] supply_slot,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [wake_seq_pkg::REG_W-1:0] reg_wdata,
  // watched outputs
  input wire logic [wake_seq_pkg::REG_W-1:0] reg_rdata,
  input wire logic [N-1:0] supply_en,
  input wire logic system_on,
  input wire logic run_from_usb,
  input wire logic trickle_100ma_en,
  input wire logic wake_summary_irq,
  input wire logic [2:0] power_state,
  input wire logic [wake_seq_pkg::SLOT_W-1:0] current_slot
);
  // ==========================================================
  // helper state: shadow mask and slot dwell counter
  typedef struct packed {
    logic [6:0] mask;
    logic [wake_seq_pkg::SLOT_W-1:0] last_slot;
    logic [15:0] dwell;
  } shadow_s;
  shadow_s cur_q, cur_d;
  logic [N-1:0] zero_slot;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      zero_slot[i] = (supply_slot[i*wake_seq_pkg::SLOT_W +: wake_seq_pkg::SLOT_W] == '0);
    end
    cur_d = cur_q;
    if (reg_wr && reg_addr == wake_seq_pkg::ADDR_WAKE_CAUSE_MASK) cur_d.mask = reg_wdata[6:0];
    cur_d.last_slot = current_slot;
    cur_d.dwell = (power_state != 3'h2 || current_slot != cur_q.last_slot) ? 16'h0001 : cur_q.dwell + 16'h0001;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) cur_q <= '0;
    else cur_q <= cur_d;
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence active_entry;
    $past(power_state) == 3'h2 && power_state == 3'h3;
  endsequence
  sequence slot_step;
    power_state == 3'h2 && $past(power_state) == 3'h2 && current_slot != cur_q.last_slot;
  endsequence
  sequence retry_hold;
    (power_state == 3'h4) [*8];
  endsequence
  chk_system_on_level: assert property (power_state == 3'h3 |-> system_on)
    else $error("system on low while active");
  chk_seq_first_slot: assert property (($past(power_state) != 3'h2 && power_state == 3'h2) |-> current_slot == 4'h1)
    else $error("sequence did not start at slot one");
  chk_active_after_last: assert property (active_entry |-> $past(current_slot) == 4'hE)
    else $error("active entered before last slot");
  chk_slot_step_one: assert property (slot_step |-> current_slot == cur_q.last_slot + 4'h1)
    else $error("slot skipped or went back");
  chk_slot_dwell_min: assert property (slot_step |-> cur_q.dwell >= SLOT_LIMIT)
    else $error("slot left too early");
  chk_zero_slot_off: assert property ((supply_en & zero_slot) == '0)
    else $error("supply without slot enabled");
  chk_fault_irq_rise: assert property (($rose(conv_fault_reset) && !cur_q.mask[4]) |=> wake_summary_irq)
    else $error("irq missing after fault cause");
  chk_all_masked_quiet: assert property ((cur_q.mask == 7'h7F && $past(cur_q.mask) == 7'h7F) |-> !wake_summary_irq)
    else $error("irq raised with all causes masked");
  chk_mask_readback: assert property (($past(reg_rd) && $past(reg_addr) == 8'h27) |->
    reg_rdata == {9'h000, $past(cur_q.mask)})
    else $error("mask read back wrong");
  chk_retry_dwell: assert property (($past(power_state) != 3'h4 && power_state == 3'h4) |-> retry_hold)
    else $error("retry wait cut short");
  chk_usb_pair: assert property (trickle_100ma_en == run_from_usb)
    else $error("trickle and usb run disagree");
endmodule : wake_seq_props

bind startup_wake_sequencer wake_seq_props #(.N(N), .SLOT_LIMIT(SLOT_LIMIT)) u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .conv_fault_reset(conv_fault_reset), .supply_slot(supply_slot),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .supply_en(supply_en), .system_on(system_on), .run_from_usb(run_from_usb),
  .trickle_100ma_en(trickle_100ma_en), .wake_summary_irq(wake_summary_irq),
  .power_state(power_state), .current_slot(current_slot)
);
`default_nettype wire

// ### supply_model.sv
// behavioural supply detectors answering the sequencer's enables
// assumes ref_clk drives it; mode: 0 prompt, 1 slow, 2 never good
`timescale 1ns/1ps
`default_nettype none
module supply_model #(
  parameter int unsigned N = 11
) (
  // clock
  input wire logic ref_clk,
  // enables and behaviour
  input wire logic [N-1:0] supply_en,
  input wire logic [1:0] mode,
  // detector levels
  output logic [N-1:0] supply_good
);
  logic [5:0] ramp_q [N];
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < N; i++) begin
      if (!supply_en[i]) ramp_q[i] <= 6'h00;
      else if (ramp_q[i] != 6'h3F) ramp_q[i] <= ramp_q[i] + 6'h01;
    end
  end
  // good at 90 percent point
  // slow ramp outlasts the slot dwell so the good level gates the advance
  always_comb begin
    for (int i = 0; i < N; i++) begin
      supply_good[i] = supply_en[i] && mode != 2'h2 && ramp_q[i] >= (mode == 2'h1 ? 6'h0C : 6'h02);
    end
  end
endmodule : supply_model
`default_nettype wire

// ### startup_wake_sequencer_test.sv
// self-checking bench: register reads and writes plus pin stimulus
// assumes the checker binds itself and supply_model answers the enables
`timescale 1ns/1ps
`default_nettype none
module startup_wake_sequencer_test;
  localparam int unsigned N = 11;
  logic ref_clk = 1'b0, rst_b = 1'b0, key_pin = 1'b1, gpio_wake_pin = 1'b0, gpio_poweron_input = 1'b0;
  logic rtc_alarm = 1'b0, adaptor_feedback = 1'b0, usb_above_line = 1'b0, line_above_startup = 1'b0;
  logic key_input_polarity = 1'b1, rtc_alarm_wake_en = 1'b0, usb_suspend = 1'b0, fault_restart_enable = 1'b0;
  logic hibernate_req = 1'b0, conv_fault_reset = 1'b0, wdog_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] gpio_pin_config = 4'h0;
  logic [N*4-1:0] supply_slot;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, rd_val, reg_rdata;
  logic [N-1:0] supply_en, supply_good;
  logic system_on, run_from_usb, trickle_100ma_en, wake_summary_irq;
  logic [2:0] power_state, prev_state;
  logic [3:0] current_slot;
  logic [1:0] mode = 2'h1;
  int num_errors = 0;
  int check_count = 0;
  int retries;
  always #25 ref_clk = ~ref_clk;
  // short counts keep the run small
  startup_wake_sequencer #(.N(N), .QUAL_LIMIT(20), .SLOT_LIMIT(8), .SLOT_TIMEOUT(40), .RETRY_LIMIT(16)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .key_pin(key_pin), .gpio_wake_pin(gpio_wake_pin),
    .gpio_poweron_input(gpio_poweron_input), .rtc_alarm(rtc_alarm), .adaptor_feedback(adaptor_feedback),
    .usb_above_line(usb_above_line), .line_above_startup(line_above_startup), .supply_good(supply_good),
    .key_input_polarity(key_input_polarity), .gpio_pin_config(gpio_pin_config),
    .rtc_alarm_wake_en(rtc_alarm_wake_en), .usb_suspend(usb_suspend),
    .fault_restart_enable(fault_restart_enable), .hibernate_req(hibernate_req), .supply_slot(supply_slot),
    .conv_fault_reset(conv_fault_reset), .wdog_reset(wdog_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .supply_en(supply_en),
    .system_on(system_on), .run_from_usb(run_from_usb), .trickle_100ma_en(trickle_100ma_en),
    .wake_summary_irq(wake_summary_irq), .power_state(power_state), .current_slot(current_slot)
  );
  supply_model #(.N(N)) u_supplies (.ref_clk(ref_clk), .supply_en(supply_en), .mode(mode), .supply_good(supply_good));
  // ==========================================================
  // access tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : reg_write
  task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    rd_val = reg_rdata;
    check(rd_val, exp);
    tick(1);
  endtask : read_check
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic wait_state(input logic [2:0] st, input int bound);
    for (int k = 0; k < bound && power_state !== st; k++) tick(1);
    if (power_state !== st) begin
      num_errors++;
      $display("mismatch at %0t: state %0d not reached", $time, st);
      test_done();
    end
    // wake-cause bits land one cycle after the state change
    tick(1);
  endtask : wait_state
  task automatic to_sleep();
    hibernate_req = 1'b1;
    wait_state(3'h1, 20);
    hibernate_req = 1'b0;
  endtask : to_sleep
  task automatic test_end(input string name);
    $display("test %s ended, mismatches %0d", name, num_errors);
  endtask : test_end
  // ==========================================================
  // scenarios
  initial begin
    for (int i = 0; i < N; i++) supply_slot[i*4 +: 4] = (i == 0) ? 4'h0 : 4'(i + 3);
    tick(6);
    rst_b = 1'b1;
    tick(1);
    read_check(8'h27, 16'h0000);
    read_check(8'h1F, 16'h0000);
    read_check(8'h00, 16'h0000);
    reg_write(8'h27, 16'hFFFF);
    tick(2);
    check(16'(wake_summary_irq), 16'h0000);
    read_check(8'h27, 16'h007F);
    reg_write(8'h1F, 16'hFFFF);
    read_check(8'h1F, 16'h0000);
    reg_write(8'h27, 16'h0000);
    adaptor_feedback = 1'b1;
    tick(12);
    check(16'(power_state), 16'h0000);
    adaptor_feedback = 1'b0;
    test_end("registers and threshold");
    line_above_startup = 1'b1;
    tick(4);
    key_pin = 1'b0;
    tick(15);
    key_pin = 1'b1;
    tick(15);
    key_pin = 1'b0;
    tick(15);
    check(16'(power_state), 16'h0000);
    wait_state(3'h2, 40);
    key_pin = 1'b1;
    wait_state(3'h3, 600);
    check({4'h0, supply_en, system_on}, 16'h0FFD);
    check(16'(wake_summary_irq), 16'h0001);
    read_check(8'h1F, 16'h0042);
    check(16'(wake_summary_irq), 16'h0000);
    read_check(8'h1F, 16'h0000);
    test_end("key start");
    conv_fault_reset = 1'b1;
    wdog_reset = 1'b1;
    tick(2);
    check(16'(wake_summary_irq), 16'h0001);
    conv_fault_reset = 1'b0;
    wdog_reset = 1'b0;
    read_check(8'h1F, 16'h0018);
    reg_write(8'h27, 16'h0010);
    conv_fault_reset = 1'b1;
    tick(3);
    check(16'(wake_summary_irq), 16'h0000);
    conv_fault_reset = 1'b0;
    read_check(8'h1F, 16'h0010);
    reg_write(8'h27, 16'h0000);
    test_end("reset causes and mask");
    to_sleep();
    rtc_alarm = 1'b1;
    tick(10);
    check(16'(power_state), 16'h0001);
    rtc_alarm_wake_en = 1'b1;
    wait_state(3'h3, 600);
    rtc_alarm = 1'b0;
    rtc_alarm_wake_en = 1'b0;
    read_check(8'h1F, 16'h0020);
    test_end("alarm wake");
    to_sleep();
    mode = 2'h2;
    gpio_pin_config = 4'h3;
    gpio_wake_pin = 1'b1;
    wait_state(3'h2, 40);
    gpio_wake_pin = 1'b0;
    wait_state(3'h0, 200);
    check({4'h0, supply_en, system_on}, 16'h0000);
    read_check(8'h1F, 16'h0001);
    mode = 2'h0;
    usb_suspend = 1'b1;
    usb_above_line = 1'b1;
    wait_state(3'h3, 600);
    check({14'h0, run_from_usb, trickle_100ma_en}, 16'h0000);
    read_check(8'h1F, 16'h0040);
    test_end("fault and suspended usb");
    to_sleep();
    mode = 2'h2;
    fault_restart_enable = 1'b1;
    gpio_pin_config = 4'hC;
    gpio_poweron_input = 1'b1;
    wait_state(3'h2, 40);
    gpio_poweron_input = 1'b0;
    retries = 0;
    prev_state = power_state;
    for (int k = 0; k < 3000 && power_state !== 3'h0; k++) begin
      if (power_state === 3'h4 && prev_state !== 3'h4) retries++;
      prev_state = power_state;
      tick(1);
    end
    check(16'(retries), 16'h0008);
    check(16'(power_state), 16'h0000);
    read_check(8'h1F, 16'h0004);
    test_end("restart attempts");
    mode = 2'h0;
    fault_restart_enable = 1'b0;
    usb_suspend = 1'b0;
    usb_above_line = 1'b0;
    tick(4);
    usb_above_line = 1'b1;
    wait_state(3'h3, 600);
    check({14'h0, run_from_usb, trickle_100ma_en}, 16'h0003);
    read_check(8'h1F, 16'h0040);
    test_end("usb power start");
    test_done();
  end
endmodule : startup_wake_sequencer_test
`default_nettype wire
